//--- shared/wwt_core_if.sv
// carrier between the watchdog top, its prescaler and its window guard
`timescale 1ns/100ps
interface wwt_core_if;
	logic       run;
	logic [1:0] div_sel;
	logic       tick;
	logic [6:0] count;
	logic [6:0] window;
	logic       count_wr;
	logic       warn;
	logic       bite;

	modport pre (input run, div_sel, output tick);
	modport guard (input run, tick, count, window, count_wr,
		output warn, bite);
	modport top (output run, div_sel, count, window, count_wr,
		input tick, warn, bite);
endinterface

//--- shared/wwt_pkg.sv
// constants, types and helpers shared by the window watchdog files
package wwt_pkg;

	// register byte offsets
	localparam logic [3:0] WWT_ADDR_CONTROL = 4'h0;
	localparam logic [3:0] WWT_ADDR_CONFIG  = 4'h4;
	localparam logic [3:0] WWT_ADDR_STATE   = 4'h8;

	// field positions
	localparam int WWT_COUNT_LSB  = 0;
	localparam int WWT_COUNT_MSB  = 6;
	localparam int WWT_ARM_BIT    = 7;
	localparam int WWT_WIN_LSB    = 0;
	localparam int WWT_WIN_MSB    = 6;
	localparam int WWT_DIV_LSB    = 7;
	localparam int WWT_DIV_MSB    = 8;
	localparam int WWT_EARLY_WARNING_IRQ_ENABLE_BIT  = 9;
	localparam int WWT_FLAG_BIT   = 0;

	// reset values
	localparam logic [31:0] WWT_CONTROL_RST = 32'h0000007F;
	localparam logic [31:0] WWT_CONFIG_RST  = 32'h0000007F;
	localparam logic [31:0] WWT_STATE_RST   = 32'h00000000;

	// counter thresholds
	localparam logic [6:0] WWT_COUNT_WARN   = 7'h40;
	localparam logic [6:0] WWT_COUNT_EXPIRE = 7'h3F;

	// timebase: bus clock cycles per base tick
	localparam int          WWT_BASE_DIV    = 4096;
	localparam logic [11:0] WWT_BASE_LAST   = 12'(WWT_BASE_DIV - 1);

	// ahb-lite encodings
	localparam logic [2:0] WWT_HSIZE_HALF = 3'h1;
	localparam logic [2:0] WWT_HSIZE_WORD = 3'h2;

	typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} wwt_phase_t;

	// last value of the post divider for each select code
	function automatic logic [2:0] wwt_div_last(input logic [1:0] sel);
		wwt_div_last = 3'((4'h1 << sel) - 4'h1);
	endfunction

endpackage

//--- src/wwt_prescaler.sv
// timebase: bus clock divided by the base factor, then by 1, 2, 4 or 8
`timescale 1ns/100ps
module wwt_prescaler
	import wwt_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	// core link
	wwt_core_if.pre   core
);

	logic [11:0] base_reg;
	logic [2:0]  post_reg;
	logic        base_wrap;

	assign base_wrap = (base_reg == WWT_BASE_LAST);

	// held at zero while disarmed so the first tick is a full period
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			base_reg <= 12'h000;
		else if (!core.run)
			base_reg <= 12'h000;
		else
			base_reg <= base_wrap ? 12'h000 : base_reg + 12'h001;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			post_reg <= 3'h0;
		else if (!core.run)
			post_reg <= 3'h0;
		else if (base_wrap)
			post_reg <= (post_reg >= wwt_div_last(core.div_sel)) ?
				3'h0 : post_reg + 3'h1;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			core.tick <= 1'b0;
		else
			core.tick <= core.run && base_wrap &&
				(post_reg >= wwt_div_last(core.div_sel));
	end

endmodule // wwt_prescaler

//--- src/wwt_top.sv
// window watchdog: ahb-lite register slave, down counter and reset request
`timescale 1ns/100ps

module wwt_top
	import wwt_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// system outputs
	output logic             irq_o,
	output logic             wdt_reset_o
);

	////////////////////////////////////////////////////////////////////////
	// internal state

	wwt_core_if core ();

	wwt_phase_t  phase_reg;
	logic [3:0]  addr_reg;
	logic        low_lane_reg;
	logic [31:0] rdata_next;

	logic [6:0]  down_count_value_reg;
	logic        watchdog_arm_reg;
	logic [6:0]  window_limit_reg;
	logic [1:0]  tick_divider_select_reg;
	logic        early_warning_irq_enable_reg;
	logic        early_warning_flag_reg;

	logic        addr_ok;
	logic        size_ok;
	logic        wr_ctrl;
	logic        wr_cfg;
	logic        wr_state;

	////////////////////////////////////////////////////////////////////////
	// submodules

	wwt_prescaler u_prescaler (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.core      (core.pre)
	);

	wwt_window_guard u_guard (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.core      (core.guard)
	);

	assign core.run      = watchdog_arm_reg;
	assign core.div_sel  = tick_divider_select_reg;
	assign core.count    = down_count_value_reg;
	assign core.window   = window_limit_reg;
	assign core.count_wr = wr_ctrl;

	////////////////////////////////////////////////////////////////////////
	// ahb-lite address phase

	assign addr_ok = hsel_i && htrans_i[1] && hready_i;

	// byte writes are not supported and are dropped; byte reads are still served
	assign size_ok = (hsize_i == WWT_HSIZE_HALF) ||
		(hsize_i == WWT_HSIZE_WORD);

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			phase_reg <= PH_IDLE;
		else if (hready_i)
		begin
			case ({addr_ok, hwrite_i})
				2'b11:   phase_reg <= size_ok ? PH_WRITE : PH_IDLE;
				2'b10:   phase_reg <= PH_READ;
				default: phase_reg <= PH_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			addr_reg     <= 4'h0;
			low_lane_reg <= 1'b0;
		end
		else if (addr_ok)
		begin
			addr_reg     <= {haddr_i[3:2], 2'b00};
			// all fields live in the low half; an upper halfword is reserved
			low_lane_reg <= (hsize_i == WWT_HSIZE_WORD) || !haddr_i[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ahb-lite data phase: write decode

	assign wr_ctrl  = (phase_reg == PH_WRITE) && low_lane_reg &&
		(addr_reg == WWT_ADDR_CONTROL);
	assign wr_cfg   = (phase_reg == PH_WRITE) && low_lane_reg &&
		(addr_reg == WWT_ADDR_CONFIG);
	assign wr_state = (phase_reg == PH_WRITE) && low_lane_reg &&
		(addr_reg == WWT_ADDR_STATE);

	////////////////////////////////////////////////////////////////////////
	// read mux, sampled in the address phase

	// read is taken from the registers at the address edge; a write in the
	// data phase just before would not be seen, but the master never
	// overlaps the two
	always_comb
	begin
		rdata_next = 32'h00000000;
		case (haddr_i[3:0] & 4'hC)
			WWT_ADDR_CONTROL:
			begin
				rdata_next[WWT_COUNT_MSB:WWT_COUNT_LSB] =
					down_count_value_reg;
				rdata_next[WWT_ARM_BIT] = watchdog_arm_reg;
			end
			WWT_ADDR_CONFIG:
			begin
				rdata_next[WWT_WIN_MSB:WWT_WIN_LSB] = window_limit_reg;
				rdata_next[WWT_DIV_MSB:WWT_DIV_LSB] = tick_divider_select_reg;
				rdata_next[WWT_EARLY_WARNING_IRQ_ENABLE_BIT] = early_warning_irq_enable_reg;
			end
			WWT_ADDR_STATE:
				rdata_next[WWT_FLAG_BIT] = early_warning_flag_reg;
			default:
				rdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h00000000;
		else if (addr_ok && !hwrite_i)
			hrdata_o <= rdata_next;
	end

	// zero wait states and always OKAY
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register

	// a write always wins over a tick so the loaded value is not lost
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			down_count_value_reg <= WWT_CONTROL_RST[WWT_COUNT_MSB:WWT_COUNT_LSB];
		else if (wr_ctrl)
			down_count_value_reg <=
				hwdata_i[WWT_COUNT_MSB:WWT_COUNT_LSB];
		else if (watchdog_arm_reg && core.tick)
			down_count_value_reg <= down_count_value_reg - 7'h01;
	end

	// only a system reset can disarm the watchdog
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			watchdog_arm_reg <= WWT_CONTROL_RST[WWT_ARM_BIT];
		else if (wr_ctrl && hwdata_i[WWT_ARM_BIT])
			watchdog_arm_reg <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// configuration register

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			window_limit_reg        <= WWT_CONFIG_RST[WWT_WIN_MSB:WWT_WIN_LSB];
			tick_divider_select_reg <= WWT_CONFIG_RST[WWT_DIV_MSB:WWT_DIV_LSB];
		end
		else if (wr_cfg)
		begin
			window_limit_reg        <= hwdata_i[WWT_WIN_MSB:WWT_WIN_LSB];
			tick_divider_select_reg <= hwdata_i[WWT_DIV_MSB:WWT_DIV_LSB];
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			early_warning_irq_enable_reg <= WWT_CONFIG_RST[WWT_EARLY_WARNING_IRQ_ENABLE_BIT];
		else if (wr_cfg && hwdata_i[WWT_EARLY_WARNING_IRQ_ENABLE_BIT])
			early_warning_irq_enable_reg <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// state register and interrupt

	// hardware set beats a software clear landing on the same edge
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			early_warning_flag_reg <= WWT_STATE_RST[WWT_FLAG_BIT];
		else if (core.warn)
			early_warning_flag_reg <= 1'b1;
		else if (wr_state && !hwdata_i[WWT_FLAG_BIT])
			early_warning_flag_reg <= 1'b0;
	end

	// the enable bit doubles as the interrupt mask
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= early_warning_flag_reg &&
				early_warning_irq_enable_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog reset request

	// one-cycle pulse; the system reset it causes also clears this block
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			wdt_reset_o <= 1'b0;
		else
			wdt_reset_o <= core.bite && watchdog_arm_reg;
	end

endmodule // wwt_top

//--- src/wwt_window_guard.sv
// detects the early warning point and the two watchdog bite causes
`timescale 1ns/100ps
module wwt_window_guard
	import wwt_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	// core link
	wwt_core_if.guard core
);

	logic decr;

	// count only moves on a tick while armed, never on the same edge as a load
	assign decr = core.run && core.tick && !core.count_wr;

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			core.warn <= 1'b0;
		else
			core.warn <= decr &&
				(core.count == 7'(WWT_COUNT_WARN + 7'h01));
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
			core.bite <= 1'b0;
		else
			core.bite <= core.run &&
				((decr && core.count == WWT_COUNT_WARN) ||
				(core.count_wr && core.count > core.window));
	end

endmodule // wwt_window_guard

//--- verif/tb_top.sv
// self-checking bench for the window watchdog
`timescale 1ns/100ps
module tb_top;
	logic        clk, rst, hsel, hwr, irq, bite, rdy, resp;
	logic [1:0]  htr;
	logic [2:0]  hsz;
	logic [31:0] ha, hwd, hrd;
	int          error_cnt, num_checks;
	wwt_top dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(ha),
		.htrans_i(htr), .hwrite_i(hwr), .hsize_i(hsz), .hwdata_i(hwd),
		.hready_i(rdy), .hrdata_o(hrd), .hreadyout_o(rdy), .hresp_o(resp),
		.irq_o(irq), .wdt_reset_o(bite));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task conclude;
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// 0 ready, 1 irq, 2 bite; an exhausted bound ends the run
	task hold(input int sel, input int lim, output int i);
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while ((sel == 0 ? rdy : sel == 1 ? irq : bite) !== 1'b1 && i < lim);
		if (i >= lim)
		begin
			error_cnt++;
			conclude();
		end
	endtask
	task xfer(input logic [3:0] a, input logic w, input logic [2:0] s,
		input logic [31:0] d, output logic [31:0] r);
		int i;
		@(posedge clk);
		hsel <= 1'b1;
		ha   <= {28'h0, a};
		htr  <= 2'h2;
		hwr  <= w;
		hsz  <= s;
		hold(0, 100, i);
		hsel <= 1'b0;
		htr  <= 2'h0;
		hwd  <= d;
		hold(0, 100, i);
		r = hrd;
	endtask
	task wt(input logic [3:0] a, input logic [31:0] d,
		input logic [2:0] s = 3'h2);
		logic [31:0] r;
		xfer(a, 1'b1, s, d, r);
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(a, 1'b0, 3'h2, 32'h0, r);
		chk(r, e);
	endtask
	task reset;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task regs_check;
		reset();
		rd(4'h0, 32'h7F);
		rd(4'h4, 32'h7F);
		rd(4'h8, 32'h0);
		rd(4'hC, 32'h0);
		wt(4'h4, 32'h3C5);
		wt(4'h4, 32'h0AA);
		rd(4'h4, 32'h2AA);
		wt(4'h0, 32'h33, 3'h0);
		rd(4'h0, 32'h7F);
		wt(4'h0, 32'h55, 3'h1);
		rd(4'h0, 32'h55);
	endtask
	// arming with the count loaded keeps the old disarmed state for the check
	task run(input logic [1:0] dv);
		int i;
		reset();
		wt(4'h4, {22'h0, 1'b1, dv, 7'h7F});
		wt(4'h0, 32'hC1);
		hold(1, 40000, i);
		chk(i >= (4096 << dv) && i <= (4096 << dv) + 8, 1);
	endtask
	// continues armed from the last run, which ended 4100 edges after arming
	task bite_run;
		int i;
		rd(4'h8, 32'h1);
		wt(4'h8, 32'h1);
		rd(4'h8, 32'h1);
		wt(4'h0, 32'h41);
		rd(4'h0, 32'hC1);
		wt(4'h8, 32'h0);
		rd(4'h8, 32'h0);
		chk(irq, 0);
		hold(2, 9000, i);
		// a count load keeps the tick phase: bite on the third tick after
		// arming, less the seven bus transfers spent above
		chk(i >= 8165 && i <= 8175, 1);
	endtask
	// the reset pulse is one cycle, two edges after the write lands
	task win_bite;
		int i;
		reset();
		wt(4'h4, 32'h50);
		wt(4'h0, 32'hFF);
		repeat (2) @(posedge clk);
		chk(bite, 0);
		wt(4'h4, 32'h7F);
		wt(4'h0, 32'h60);
		repeat (2) @(posedge clk);
		chk(bite, 0);
		wt(4'h4, 32'h50);
		wt(4'h0, 32'h60);
		hold(2, 6, i);
		chk(i, 2);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst        = 1'b1;
		hsel       = 1'b0;
		ha         = 32'h0;
		htr        = 2'h0;
		hwr        = 1'b0;
		hsz        = 3'h0;
		hwd        = 32'h0;
		error_cnt  = 0;
		num_checks = 0;
		regs_check();
		run(2'h3);
		run(2'h0);
		bite_run();
		win_bite();
		conclude();
	end
endmodule // tb_top

//--- verif/wwt_assertions.sv
// port assertions for the window watchdog top
`timescale 1ns/100ps
module wwt_assertions
(
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// bus and outputs
	input wire logic        hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0]  htrans_i,
	input wire logic        hwrite_i,
	input wire logic [2:0]  hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic        hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        irq_o,
	input wire logic        wdt_reset_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic       wr_reg;
	logic       rd_reg;
	logic       arm_reg;
	logic       ie_reg;
	logic [3:0] a_reg;
	logic [2:0] age_reg;
	wire        tk = hsel_i & htrans_i[1] & hready_i;
	// byte writes never reach a register, so they are not tracked
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_reg  <= 1'b0;
			rd_reg  <= 1'b0;
			arm_reg <= 1'b0;
			ie_reg  <= 1'b0;
			a_reg   <= 4'h0;
			age_reg <= 3'h7;
		end
		else
		begin
			wr_reg  <= tk & hwrite_i & (hsize_i != 3'h0);
			rd_reg  <= tk & ~hwrite_i;
			a_reg   <= tk ? haddr_i[3:0] : a_reg;
			arm_reg <= arm_reg | (wr_reg & a_reg == 4'h0 & hwdata_i[7]);
			ie_reg  <= ie_reg | (wr_reg & a_reg == 4'h4 & hwdata_i[9]);
			age_reg <= (wr_reg & a_reg == 4'h8) ? 3'h0 :
				(age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
		end
	end
	sequence s_quiet;
		!wdt_reset_o [*3];
	endsequence
	AST_READY: assert property (hreadyout_o)
		else $error("hreadyout low");
	AST_OKAY: assert property (!hresp_o)
		else $error("response not okay");
	AST_PULSE: assert property (wdt_reset_o |=> s_quiet)
		else $error("reset pulse too long");
	AST_ARMED: assert property (wdt_reset_o |-> arm_reg)
		else $error("reset while never armed");
	AST_EARLY_WARNING_IRQ_ENABLE: assert property ($rose(irq_o) |-> ie_reg)
		else $error("irq without enable");
	AST_IRQ_FALL: assert property ($fell(irq_o) |-> age_reg <= 3'h3)
		else $error("irq dropped without clear");
	AST_RSVD: assert property (rd_reg |-> hrdata_o[31:10] == 22'h0
		&& (a_reg != 4'hC || hrdata_o == 32'h0))
		else $error("reserved read not zero");
	AST_RST: assert property ($fell(rst_i) |-> !irq_o && !wdt_reset_o)
		else $error("outputs active after reset");
endmodule // wwt_assertions
bind wwt_top wwt_assertions u_chk (.*);
